// File: rtl/xpd_top.sv
// x-bus peripheral decoder: apb register file, decode and registered strobes
// assumes i/o cycles arrive on i_clk_sys from host bus logic, held per cycle
//
// Notes on behaviour
// - ide decode off stops ide chip selects and transceiver enable.
// - power-managed variant still enables transceiver for 377h and 3F7h.
// - keyboard decode off stops keyboard selects and transceiver enable.
// - keyboard enable gates both settings of keyboard mapping.
// - clock decode off stops latch, read, write and transceiver.
// - serial and printer transceiver enable only for enabled decodes.
// - config ram bit enables page write and ram range strobes.
// - port 92 decode resets enabled; writing zero disables it.
// - printer field picks first, second, third range, or off.
// - keyboard mapped off bus keeps selects, drops transceiver enable.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module xpd_top (
	input  wire logic              i_clk_sys,
	input  wire logic              i_srst,
	input  wire xpd_pkg::xpd_apb_s i_apb,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire xpd_pkg::xpd_io_s  i_io,
	output xpd_pkg::xpd_xout_s     o_xout
);
	import xpd_pkg::*;

	xpd_state_s state_r;
	xpd_state_s state_nxt;
	xpd_xout_s  hit;
	logic [2:0] sel;
	logic       wr_go;
	logic       rd_go;
	logic [7:0] rd_val;

	// range decode of the current cycle
	xpd_decode u_decode (
		.i_pm_variant (state_r.ctrl[C_PM]),
		.i_dec_a      (state_r.dec_a),
		.i_dec_b      (state_r.dec_b),
		.i_io         (i_io),
		.o_hit        (hit)
	);

	// apb handshake, zero wait states
	always_comb begin
		sel       = xpd_reg_sel(i_apb.paddr);
		o_pready  = i_apb.psel && i_apb.penable;
		o_pslverr = o_pready && !sel[2];
		wr_go     = o_pready && i_apb.pwrite && sel[2];
		rd_go     = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
	end

	// read multiplexer
	always_comb begin
		case (sel)
			3'h4:    rd_val = state_r.dec_a;
			3'h5:    rd_val = state_r.dec_b;
			3'h6:    rd_val = state_r.status;
			3'h7:    rd_val = state_r.ctrl;
			default: rd_val = 8'h00;
		endcase
	end

	// next state
	always_comb begin
		state_nxt = state_r;
		// read data captured in the setup cycle
		if (rd_go) begin
			state_nxt.prdata = {24'h000000, rd_val};
		end
		if (wr_go) begin
			case (sel)
				3'h4: state_nxt.dec_a = i_apb.pwdata[7:0] & DEC_A_MASK;
				3'h5: state_nxt.dec_b = i_apb.pwdata[7:0];
				3'h7: state_nxt.ctrl  = i_apb.pwdata[7:0] & CTRL_MASK;
				default: begin
				end
			endcase
		end
		// strobes follow the cycle, idle at its end
		state_nxt.xo = i_io.cycle ? hit : XOUT_IDLE;
		// last cycle summary for software
		if (i_io.cycle) begin
			state_nxt.status = {!hit.xbus_transceiver_enable_n, hit.lpt_cs,
				hit.port92_sel, !hit.config_ram_read_n || !hit.config_ram_write_n,
				!hit.clock_chip_write_n || hit.clock_chip_read ||
				hit.clock_chip_addr_latch,
				hit.kbd_cs, hit.ide_ctl_cs, hit.ide_task_cs};
		end
	end

	// state register
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_r.dec_a  <= DEC_A_RST;
			state_r.dec_b  <= DEC_B_RST;
			state_r.ctrl   <= CTRL_RST;
			state_r.status <= STATUS_RST;
			state_r.prdata <= 32'h00000000;
			state_r.xo     <= XOUT_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs from flip-flops
	always_comb begin
		o_prdata = state_r.prdata;
		o_xout   = state_r.xo;
	end

	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);

	logic [15:0] ia;
	logic        ic;
	logic        iw;
	always_comb begin
		ia = i_io.addr;
		ic = i_io.cycle;
		iw = i_io.write;
	end

	a_ide_off_nocs: assert property (
		ic && !state_r.dec_a[A_IDE] |=> !o_xout.ide_task_cs && !o_xout.ide_ctl_cs)
		else $error("ide select while ide decode off");

	a_ide_off_noxcvr: assert property (
		ic && !state_r.dec_a[A_IDE] && !state_r.ctrl[C_PM] &&
		(ia == IDE_PRI_TOP || ia == IDE_SEC_TASK)
		|=> o_xout.xbus_transceiver_enable_n)
		else $error("transceiver on for disabled ide");

	a_ide_pm_keep: assert property (
		ic && !state_r.dec_a[A_IDE] && state_r.ctrl[C_PM] &&
		(ia == IDE_PRI_TOP || ia == IDE_SEC_TOP)
		|=> !o_xout.xbus_transceiver_enable_n && !o_xout.ide_ctl_cs)
		else $error("top ide control lost transceiver");

	a_kbd_off: assert property (
		ic && !state_r.dec_a[A_KBD] && (ia == KBD_DATA || ia == KBD_CMD)
		|=> !o_xout.kbd_cs && o_xout.xbus_transceiver_enable_n)
		else $error("keyboard decoded while disabled");

	a_kbd_gate: assert property (
		ic && !state_r.dec_a[A_KBD] |=> !o_xout.kbd_cs)
		else $error("keyboard select without enable");

	a_rtc_off: assert property (
		ic && !state_r.dec_a[A_RTC] && xpd_in_block(ia, RTC_BASE, M_8)
		|=> !o_xout.clock_chip_addr_latch && !o_xout.clock_chip_read &&
		o_xout.clock_chip_write_n && o_xout.xbus_transceiver_enable_n)
		else $error("clock chip strobe while disabled");

	a_lpt_off: assert property (
		ic && state_r.dec_b[B_LPT+:2] == SEL_OFF && ia == LPT2_BASE
		|=> o_xout.xbus_transceiver_enable_n && !o_xout.lpt_cs)
		else $error("printer decoded while off");

	a_com_on: assert property (
		ic && state_r.dec_b[B_COMA+:2] == SEL_FIRST && ia == COM1_BASE
		|=> !o_xout.xbus_transceiver_enable_n)
		else $error("serial transceiver missing");

	a_cram_strobe: assert property (
		ic && state_r.dec_b[B_CRAM] && xpd_in_block(ia, CRAM_BASE, M_256)
		|=> (o_xout.config_ram_read_n == $past(iw)) &&
		(o_xout.config_ram_write_n == !$past(iw)))
		else $error("config ram strobe wrong");

	a_cram_off: assert property (
		!state_r.dec_b[B_CRAM] |=> o_xout.config_ram_read_n &&
		o_xout.config_ram_write_n && !o_xout.config_page_write)
		else $error("config ram strobe while disabled");

	a_p92_reset: assert property (
		$fell(i_srst) |-> state_r.dec_b[B_P92] ##1 1'b1)
		else $error("port 92 decode not enabled at reset");

	a_p92_off: assert property (
		ic && !state_r.dec_b[B_P92] && ia == PORT92 |=> !o_xout.port92_sel)
		else $error("port 92 decoded while disabled");

	a_lpt_select: assert property (
		ic && ((state_r.dec_b[B_LPT+:2] == SEL_FIRST && ia == LPT1_BASE) ||
		(state_r.dec_b[B_LPT+:2] == SEL_SECOND && ia == LPT2_BASE) ||
		(state_r.dec_b[B_LPT+:2] == SEL_THIRD && ia == LPT3_BASE))
		|=> o_xout.lpt_cs)
		else $error("printer range not selected");

	a_kbd_mapped: assert property (
		ic && state_r.dec_a[A_KBD] && state_r.dec_a[A_KMAP] && ia == KBD_DATA
		|=> o_xout.kbd_cs && o_xout.xbus_transceiver_enable_n)
		else $error("mapped keyboard cycle wrong");

	a_cycle_end: assert property (
		!ic |=> o_xout == XOUT_IDLE)
		else $error("strobe outside i/o cycle");

	// ide ranges, both polarities of the enable
	a_ide_pri_task: assert property (
		ic && state_r.dec_a[A_IDE] && !state_r.dec_a[A_SEC] &&
		xpd_in_block(ia, IDE_PRI_TASK, M_8) |=> o_xout.ide_task_cs)
		else $error("primary ide task select missing");

	a_ide_sec_task: assert property (
		ic && state_r.dec_a[A_IDE] && state_r.dec_a[A_SEC] &&
		xpd_in_block(ia, IDE_SEC_TASK, M_8) |=> o_xout.ide_task_cs)
		else $error("secondary ide task select missing");

	a_ide_off_task: assert property (
		ic && !state_r.dec_a[A_IDE] && (xpd_in_block(ia, IDE_PRI_TASK, M_8) ||
		xpd_in_block(ia, IDE_SEC_TASK, M_8))
		|=> !o_xout.ide_task_cs && o_xout.xbus_transceiver_enable_n)
		else $error("ide task range decoded while off");

	a_ide_off_ctl: assert property (
		ic && !state_r.dec_a[A_IDE] && (ia == IDE_PRI_CTL || ia == IDE_SEC_CTL)
		|=> !o_xout.ide_ctl_cs && o_xout.xbus_transceiver_enable_n)
		else $error("ide control decoded while off");

	a_ide_top_off: assert property (
		ic && !state_r.dec_a[A_IDE] && !state_r.ctrl[C_PM] &&
		(ia == IDE_PRI_TOP || ia == IDE_SEC_TOP)
		|=> o_xout.xbus_transceiver_enable_n && !o_xout.ide_ctl_cs)
		else $error("top ide control kept without variant");

	// keyboard and clock chip strobes
	a_kbd_on_bus: assert property (
		ic && state_r.dec_a[A_KBD] && !state_r.dec_a[A_KMAP] &&
		(ia == KBD_DATA || ia == KBD_CMD)
		|=> o_xout.kbd_cs && !o_xout.xbus_transceiver_enable_n)
		else $error("keyboard on bus not decoded");

	a_kbd_cmd_mapped: assert property (
		ic && state_r.dec_a[A_KBD] && state_r.dec_a[A_KMAP] && ia == KBD_CMD
		|=> o_xout.kbd_cs && o_xout.xbus_transceiver_enable_n)
		else $error("mapped keyboard command cycle wrong");

	a_rtc_latch: assert property (
		ic && state_r.dec_a[A_RTC] && iw && !ia[0] && xpd_in_block(ia, RTC_BASE, M_8)
		|=> o_xout.clock_chip_addr_latch && !o_xout.xbus_transceiver_enable_n)
		else $error("clock chip latch missing");

	a_rtc_write: assert property (
		ic && state_r.dec_a[A_RTC] && iw && ia[0] && xpd_in_block(ia, RTC_BASE, M_8)
		|=> !o_xout.clock_chip_write_n)
		else $error("clock chip write missing");

	a_rtc_read: assert property (
		ic && state_r.dec_a[A_RTC] && !iw && ia[0] && xpd_in_block(ia, RTC_BASE, M_8)
		|=> o_xout.clock_chip_read)
		else $error("clock chip read missing");

	// config ram page and port 92
	a_cram_page: assert property (
		ic && state_r.dec_b[B_CRAM] && iw && ia == CRAM_PAGE
		|=> o_xout.config_page_write && !o_xout.xbus_transceiver_enable_n)
		else $error("config page write missing");

	a_page_read: assert property (
		ic && !iw && ia == CRAM_PAGE |=> !o_xout.config_page_write)
		else $error("config page strobe on read");

	a_page_off: assert property (
		ic && !state_r.dec_b[B_CRAM] && ia == CRAM_PAGE
		|=> o_xout.xbus_transceiver_enable_n && !o_xout.config_page_write)
		else $error("config page decoded while off");

	a_p92_on: assert property (
		ic && state_r.dec_b[B_P92] && ia == PORT92 |=> o_xout.port92_sel)
		else $error("port 92 not decoded");

	a_p92_wr_zero: assert property (
		wr_go && sel == 3'h5 && !i_apb.pwdata[B_P92] |=> !state_r.dec_b[B_P92])
		else $error("port 92 decode not cleared by write");

	// printer and serial ranges
	a_lpt_first: assert property (
		ic && state_r.dec_b[B_LPT+:2] == SEL_FIRST && xpd_in_block(ia, LPT1_BASE, M_4)
		|=> o_xout.lpt_cs)
		else $error("first printer range missed");

	a_lpt_third: assert property (
		ic && state_r.dec_b[B_LPT+:2] == SEL_THIRD && xpd_in_block(ia, LPT3_BASE, M_8)
		|=> o_xout.lpt_cs)
		else $error("third printer range missed");

	a_lpt_off_all: assert property (
		ic && state_r.dec_b[B_LPT+:2] == SEL_OFF && (xpd_in_block(ia, LPT1_BASE, M_4) ||
		xpd_in_block(ia, LPT3_BASE, M_8))
		|=> !o_xout.lpt_cs && o_xout.xbus_transceiver_enable_n)
		else $error("printer transceiver while off");

	a_lpt_xcvr: assert property (
		ic && state_r.dec_b[B_LPT+:2] == SEL_SECOND && xpd_in_block(ia, LPT2_BASE, M_8)
		|=> o_xout.lpt_cs && !o_xout.xbus_transceiver_enable_n)
		else $error("printer transceiver missing");

	a_com_off: assert property (
		ic && state_r.dec_b[B_COMA+:2] == SEL_OFF && state_r.dec_b[B_COMB+:2] == SEL_OFF &&
		xpd_in_block(ia, COM1_BASE, M_8) |=> o_xout.xbus_transceiver_enable_n)
		else $error("serial transceiver while off");

	// main scenarios reached
	c_kbd_mapped: cover property (
		ic && state_r.dec_a[A_KBD] && state_r.dec_a[A_KMAP] ##1 o_xout.kbd_cs);
	c_pm_keep: cover property (
		ic && state_r.ctrl[C_PM] && !state_r.dec_a[A_IDE] && ia == IDE_PRI_TOP);
	c_cram_write: cover property (
		ic && iw ##1 !o_xout.config_ram_write_n);
	c_apb_write_b: cover property (
		wr_go && sel == 3'h5 ##1 !state_r.dec_b[B_P92]);
	c_lpt_third: cover property (
		ic && state_r.dec_b[B_LPT+:2] == SEL_THIRD ##1 o_xout.lpt_cs);

endmodule : xpd_top

// File: shared/xpd_pkg.sv
// constants, types and helper functions of the x-bus peripheral decoder
// assumes a 12-bit apb byte address and 16-bit i/o cycle addresses
package xpd_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_DEC_A    = 8'h4E;
	localparam logic [7:0]  IDX_DEC_B    = 8'h4F;
	localparam logic [7:0]  IDX_STATUS   = 8'h40;
	localparam logic [7:0]  IDX_CTRL     = 8'h41;

	// reset values and writable bits
	localparam logic [7:0]  DEC_A_RST    = 8'h13;
	localparam logic [7:0]  DEC_A_MASK   = 8'h73;
	localparam logic [7:0]  DEC_B_RST    = 8'hCF;
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [7:0]  CTRL_MASK    = 8'h01;
	localparam logic [7:0]  STATUS_RST   = 8'h00;

	// field positions
	localparam int unsigned A_RTC        = 0;
	localparam int unsigned A_KBD        = 1;
	localparam int unsigned A_IDE        = 4;
	localparam int unsigned A_SEC        = 5;
	localparam int unsigned A_KMAP       = 6;
	localparam int unsigned B_COMA       = 0;
	localparam int unsigned B_COMB       = 2;
	localparam int unsigned B_LPT        = 4;
	localparam int unsigned B_P92        = 6;
	localparam int unsigned B_CRAM       = 7;
	localparam int unsigned C_PM         = 0;

	// field codes
	localparam logic [1:0]  SEL_FIRST    = 2'b00;
	localparam logic [1:0]  SEL_SECOND   = 2'b01;
	localparam logic [1:0]  SEL_THIRD    = 2'b10;
	localparam logic [1:0]  SEL_OFF      = 2'b11;

	// i/o locations and range masks
	localparam logic [15:0] IDE_PRI_TASK = 16'h01F0;
	localparam logic [15:0] IDE_SEC_TASK = 16'h0170;
	localparam logic [15:0] IDE_PRI_CTL  = 16'h03F6;
	localparam logic [15:0] IDE_SEC_CTL  = 16'h0376;
	localparam logic [15:0] IDE_PRI_TOP  = 16'h03F7;
	localparam logic [15:0] IDE_SEC_TOP  = 16'h0377;
	localparam logic [15:0] KBD_DATA     = 16'h0060;
	localparam logic [15:0] KBD_CMD      = 16'h0064;
	localparam logic [15:0] RTC_BASE     = 16'h0070;
	localparam logic [15:0] PORT92       = 16'h0092;
	localparam logic [15:0] CRAM_BASE    = 16'h0800;
	localparam logic [15:0] CRAM_PAGE    = 16'h0C00;
	localparam logic [15:0] LPT1_BASE    = 16'h03BC;
	localparam logic [15:0] LPT2_BASE    = 16'h0378;
	localparam logic [15:0] LPT3_BASE    = 16'h0278;
	localparam logic [15:0] COM1_BASE    = 16'h03F8;
	localparam logic [15:0] COM2_BASE    = 16'h02F8;
	localparam logic [15:0] M_2          = 16'h0001;
	localparam logic [15:0] M_4          = 16'h0003;
	localparam logic [15:0] M_8          = 16'h0007;
	localparam logic [15:0] M_256        = 16'h00FF;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} xpd_apb_s;

	typedef struct packed {
		logic        cycle;
		logic        write;
		logic [15:0] addr;
	} xpd_io_s;

	typedef struct packed {
		logic ide_task_cs;
		logic ide_ctl_cs;
		logic kbd_cs;
		logic clock_chip_addr_latch;
		logic clock_chip_read;
		logic clock_chip_write_n;
		logic config_ram_read_n;
		logic config_ram_write_n;
		logic config_page_write;
		logic port92_sel;
		logic lpt_cs;
		logic xbus_transceiver_enable_n;
	} xpd_xout_s;

	localparam xpd_xout_s XOUT_IDLE = 12'h071;

	typedef struct packed {
		logic [7:0]  dec_a;
		logic [7:0]  dec_b;
		logic [7:0]  ctrl;
		logic [7:0]  status;
		logic [31:0] prdata;
		xpd_xout_s   xo;
	} xpd_state_s;

	// address falls in the block base..base+mask
	function automatic logic xpd_in_block(input logic [15:0] a, input logic [15:0] base,
		input logic [15:0] m);
		return (a & ~m) == base;
	endfunction : xpd_in_block

	// serial port field decode
	function automatic logic xpd_com_hit(input logic [1:0] sel, input logic [15:0] a);
		return ((sel == SEL_FIRST) && xpd_in_block(a, COM1_BASE, M_8)) ||
			((sel == SEL_SECOND) && xpd_in_block(a, COM2_BASE, M_8));
	endfunction : xpd_com_hit

	// apb register select: {mapped, which}
	function automatic logic [2:0] xpd_reg_sel(input logic [11:0] paddr);
		logic [2:0] r;
		r = 3'h0;
		if (paddr == {2'h0, IDX_DEC_A, 2'h0}) r = 3'h4;
		if (paddr == {2'h0, IDX_DEC_B, 2'h0}) r = 3'h5;
		if (paddr == {2'h0, IDX_STATUS, 2'h0}) r = 3'h6;
		if (paddr == {2'h0, IDX_CTRL, 2'h0}) r = 3'h7;
		return r;
	endfunction : xpd_reg_sel

endpackage : xpd_pkg

// File: rtl/xpd_decode.sv
// combinational range decoder for one i/o cycle
// assumes the decode registers and cycle come from the same clock domain
`timescale 1ns/1ps
module xpd_decode (
	input  wire logic              i_pm_variant,
	input  wire logic [7:0]        i_dec_a,
	input  wire logic [7:0]        i_dec_b,
	input  wire xpd_pkg::xpd_io_s  i_io,
	output xpd_pkg::xpd_xout_s     o_hit
);
	import xpd_pkg::*;

	logic [15:0] a;
	logic        on;
	logic        sec;
	logic        ide_task;
	logic        ide_ctl;
	logic        ide_keep;
	logic        kbd;
	logic        rtc;
	logic        cram;
	logic        page;
	logic        lpt;
	logic        serial;

	// range hits gated by their enables
	always_comb begin
		a   = i_io.addr;
		on  = i_io.cycle;
		sec = i_dec_a[A_SEC];
		ide_task = on && i_dec_a[A_IDE] &&
			xpd_in_block(a, sec ? IDE_SEC_TASK : IDE_PRI_TASK, M_8);
		ide_ctl  = on && i_dec_a[A_IDE] &&
			xpd_in_block(a, sec ? IDE_SEC_CTL : IDE_PRI_CTL, M_2);
		ide_keep = on && !i_dec_a[A_IDE] && i_pm_variant &&
			(a == IDE_PRI_TOP || a == IDE_SEC_TOP);
		kbd  = on && i_dec_a[A_KBD] && (a == KBD_DATA || a == KBD_CMD);
		rtc  = on && i_dec_a[A_RTC] && xpd_in_block(a, RTC_BASE, M_8);
		cram = on && i_dec_b[B_CRAM] && xpd_in_block(a, CRAM_BASE, M_256);
		page = on && i_dec_b[B_CRAM] && i_io.write && (a == CRAM_PAGE);
		case (i_dec_b[B_LPT+:2])
			SEL_FIRST:  lpt = on && xpd_in_block(a, LPT1_BASE, M_4);
			SEL_SECOND: lpt = on && xpd_in_block(a, LPT2_BASE, M_8);
			SEL_THIRD:  lpt = on && xpd_in_block(a, LPT3_BASE, M_8);
			default:    lpt = 1'b0;
		endcase
		serial = on && (xpd_com_hit(i_dec_b[B_COMA+:2], a) ||
			xpd_com_hit(i_dec_b[B_COMB+:2], a));
	end

	// strobes and transceiver enable
	always_comb begin
		o_hit = XOUT_IDLE;
		o_hit.ide_task_cs           = ide_task;
		o_hit.ide_ctl_cs            = ide_ctl;
		o_hit.kbd_cs                = kbd;
		o_hit.clock_chip_addr_latch = rtc && i_io.write && !a[0];
		o_hit.clock_chip_read       = rtc && !i_io.write && a[0];
		o_hit.clock_chip_write_n    = !(rtc && i_io.write && a[0]);
		o_hit.config_ram_read_n     = !(cram && !i_io.write);
		o_hit.config_ram_write_n    = !(cram && i_io.write);
		o_hit.config_page_write     = page;
		o_hit.port92_sel            = on && i_dec_b[B_P92] && (a == PORT92);
		o_hit.lpt_cs                = lpt;
		o_hit.xbus_transceiver_enable_n = !(ide_task || ide_ctl || ide_keep ||
			(kbd && !i_dec_a[A_KMAP]) || rtc || cram || page || lpt || serial);
	end

endmodule : xpd_decode

// File: verif/xpd_xbus_periph.sv
// x-bus peripheral stand-in that counts keyboard controller selections
// assumes registered decoder strobes on the same clock as the decoder
`timescale 1ns/1ps
module xpd_xbus_periph (
	input  wire logic               i_clk_sys,
	input  wire logic               i_srst,
	input  wire xpd_pkg::xpd_xout_s i_xout,
	output logic [7:0]              o_kbd_hits
);
	import xpd_pkg::*;
	logic prev_r;
	// one count per new select, so a held select is one access
	always_ff @(posedge i_clk_sys) begin
		prev_r     <= i_srst ? 1'b0 : i_xout.kbd_cs;
		o_kbd_hits <= i_srst ? 8'h00 : o_kbd_hits + {7'h00, i_xout.kbd_cs & ~prev_r};
	end
endmodule : xpd_xbus_periph

// File: verif/test_xpd_top.sv
// self-checking bench of the x-bus peripheral decoder, one task per scenario
// assumes a zero-wait apb slave and strobes registered one clock after the cycle
`timescale 1ns/1ps
module test_xpd_top;
	import xpd_pkg::*;
	localparam logic [11:0] RG_A = {2'h0, IDX_DEC_A, 2'h0};
	localparam logic [11:0] RG_B = {2'h0, IDX_DEC_B, 2'h0};
	localparam logic [11:0] RG_S = {2'h0, IDX_STATUS, 2'h0};
	localparam logic [11:0] RG_C = {2'h0, IDX_CTRL, 2'h0};
	// toggles of each strobe away from its idle level, msb first
	localparam logic [11:0] T_TASK = 12'h800, T_CTL = 12'h400, T_KBD = 12'h200;
	localparam logic [11:0] T_ALE = 12'h100, T_RD = 12'h080, T_WR = 12'h040;
	localparam logic [11:0] T_CRD = 12'h020, T_CWR = 12'h010, T_PG = 12'h008;
	localparam logic [11:0] T_P92 = 12'h004, T_LPT = 12'h002, T_X = 12'h001;
	localparam logic [11:0] IDLE = T_WR | T_CRD | T_CWR | T_X;
	localparam logic [11:0] ALL = 12'hFFF;
	logic        i_clk_sys;
	logic        i_srst;
	xpd_apb_s    apb;
	xpd_io_s     io_c;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	xpd_xout_s   xout;
	logic [7:0]  kbd_hits;
	int          num_errors;
	int          samples_checked;

	xpd_top DUT (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_apb(apb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_io(io_c), .o_xout(xout));
	xpd_xbus_periph u_periph (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_xout(xout),
		.o_kbd_hits(kbd_hits));

	// 200 MHz clock
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic cmp32(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : cmp32

	task automatic cmpx(input logic [11:0] e, input logic [11:0] c, input string m);
		samples_checked++;
		if ((xout & c) !== (e & c)) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, xout, e);
		end
	endtask : cmpx

	// one apb transfer, request held until pready is seen at an edge
	task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge i_clk_sys);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
		@(posedge i_clk_sys);
		apb.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		apb <= '0;
		if (pready !== 1'b1) begin
			cmp32(32'h0, 32'h1, "apb timeout");
			report_and_stop();
		end
	endtask : apb_xfer

	task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        e;
		apb_xfer(1'b1, a, d, rd, e);
		cmp32({31'h0, e}, 32'h0, "write err");
	endtask : reg_wr

	task automatic reg_chk(input logic [11:0] a, input logic [31:0] d, input logic ee,
		input string m);
		logic [31:0] rd;
		logic        e;
		apb_xfer(1'b0, a, 8'h00, rd, e);
		cmp32(rd, d, m);
		cmp32({31'h0, e}, {31'h0, ee}, m);
	endtask : reg_chk

	// one i/o cycle: strobes one clock late, idle once the cycle ends
	task automatic io(input logic [15:0] a, input logic w, input logic [11:0] t,
		input logic [11:0] c, input string m);
		@(posedge i_clk_sys);
		io_c <= '{cycle: 1'b1, write: w, addr: a};
		@(posedge i_clk_sys);
		#1 cmpx(IDLE ^ t, c, m);
		@(posedge i_clk_sys);
		io_c <= '0;
		@(posedge i_clk_sys);
		#1 cmpx(IDLE, ALL, "idle");
	endtask : io

	task automatic t_regs();
		logic [31:0] rd;
		logic        e;
		reg_chk(RG_A, 32'h13, 1'b0, "dec_a");
		reg_chk(RG_B, 32'hCF, 1'b0, "dec_b");
		reg_chk(RG_C, 32'h00, 1'b0, "ctrl");
		reg_wr(RG_S, 8'hFF);
		reg_chk(RG_S, 32'h00, 1'b0, "status");
		apb_xfer(1'b1, 12'h200, 8'hFF, rd, e);
		cmp32({31'h0, e}, 32'h1, "unmapped wr");
		reg_chk(12'h200, 32'h0, 1'b1, "unmapped rd");
	endtask : t_regs

	task automatic t_kbd();
		io(KBD_DATA, 1'b0, T_KBD | T_X, ALL, "kbd");
		reg_chk(RG_S, 32'h84, 1'b0, "status kbd");
		io(KBD_CMD, 1'b1, T_KBD | T_X, ALL, "kbd cmd");
		reg_wr(RG_A, 8'h53);
		io(KBD_DATA, 1'b0, T_KBD, ALL, "kbd off bus");
		reg_wr(RG_A, 8'h51);
		io(KBD_DATA, 1'b0, 12'h0, ALL, "kbd map off");
		reg_wr(RG_A, 8'h11);
		io(KBD_CMD, 1'b0, 12'h0, ALL, "kbd off");
		cmp32({24'h0, kbd_hits}, 32'h3, "kbd hits");
		reg_wr(RG_A, 8'h13);
	endtask : t_kbd

	task automatic t_ide();
		io(IDE_PRI_TASK + 16'h7, 1'b0, T_TASK | T_X, ALL, "ide");
		io(IDE_PRI_CTL, 1'b1, T_CTL | T_X, ALL, "ide ctl");
		reg_wr(RG_A, 8'h33);
		io(IDE_SEC_TASK, 1'b0, T_TASK | T_X, ALL, "ide sec");
		io(IDE_SEC_TOP, 1'b0, T_CTL | T_X, ALL, "ide sec ctl");
		reg_wr(RG_A, 8'h03);
		io(IDE_PRI_TASK, 1'b0, 12'h0, ALL, "ide off");
		io(IDE_PRI_TOP, 1'b1, 12'h0, ALL, "ide off ctl");
		reg_wr(RG_C, 8'h01);
		io(IDE_PRI_TOP, 1'b1, T_X, ALL, "pm top");
		io(IDE_SEC_TOP, 1'b0, T_X, ALL, "pm sec top");
		io(IDE_PRI_CTL, 1'b0, 12'h0, ALL, "pm ctl");
		reg_wr(RG_C, 8'h00);
		reg_wr(RG_A, 8'h13);
	endtask : t_ide

	task automatic t_clk();
		io(RTC_BASE, 1'b1, T_ALE | T_X, ALL, "latch");
		io(RTC_BASE + 16'h1, 1'b1, T_WR | T_X, ALL, "clk wr");
		io(RTC_BASE + 16'h7, 1'b0, T_RD | T_X, ALL, "clk rd");
		reg_wr(RG_A, 8'h12);
		io(RTC_BASE, 1'b1, 12'h0, ALL, "latch off");
		io(RTC_BASE + 16'h1, 1'b0, 12'h0, ALL, "clk rd off");
		reg_wr(RG_A, 8'h13);
	endtask : t_clk

	task automatic t_cram();
		io(CRAM_BASE, 1'b0, T_CRD | T_X, ALL, "cram rd");
		io(CRAM_BASE + 16'hFF, 1'b1, T_CWR | T_X, ALL, "cram wr");
		io(CRAM_PAGE, 1'b1, T_PG | T_X, ALL, "page");
		io(16'h0900, 1'b0, 12'h0, ALL, "past cram");
		reg_wr(RG_B, 8'h4F);
		io(CRAM_BASE, 1'b1, 12'h0, ALL, "cram off");
		io(CRAM_PAGE, 1'b1, 12'h0, ALL, "page off");
		io(PORT92, 1'b1, T_P92, ALL, "p92");
		reg_wr(RG_B, 8'h0F);
		io(PORT92, 1'b0, 12'h0, ALL, "p92 off");
		reg_wr(RG_B, 8'hCF);
	endtask : t_cram

	task automatic t_ports();
		logic [15:0] top [3];
		top = '{16'h03BF, 16'h037F, 16'h027F};
		for (int s = 0; s < 4; s++) begin
			reg_wr(RG_B, {2'b11, s[1:0], 4'hF});
			for (int k = 0; k < 3; k++) begin
				io(top[k], 1'b0, (s == k) ? (T_LPT | T_X) : 12'h0, ALL, "lpt");
			end
		end
		reg_wr(RG_B, 8'hCC);
		io(COM1_BASE + 16'h7, 1'b0, T_X, ALL, "com a");
		reg_wr(RG_B, 8'hC7);
		io(COM2_BASE, 1'b1, T_X, ALL, "com b");
		io(COM1_BASE, 1'b1, 12'h0, ALL, "com a off");
		reg_wr(RG_B, 8'hCF);
	endtask : t_ports

	// mid-run reset brings port 92 decode back on
	task automatic t_reset();
		reg_wr(RG_B, 8'h0F);
		reg_chk(RG_B, 32'h0F, 1'b0, "p92 cleared");
		@(posedge i_clk_sys);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		reg_chk(RG_B, 32'hCF, 1'b0, "dec_b after reset");
		io(PORT92, 1'b0, T_P92, ALL, "p92 after reset");
	endtask : t_reset

	// reset, then every scenario in turn
	initial begin
		i_srst = 1'b1;
		apb = '0;
		io_c = '0;
		num_errors = 0;
		samples_checked = 0;
		repeat (20) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		t_regs();
		$display("done: registers");
		t_kbd();
		$display("done: keyboard");
		t_ide();
		$display("done: ide");
		t_clk();
		$display("done: clock chip");
		t_cram();
		$display("done: config ram and port 92");
		t_ports();
		$display("done: printer and serial");
		t_reset();
		$display("done: reset");
		report_and_stop();
	end
endmodule : test_xpd_top
